/* File: hw/alkb_key_builder.sv */
// Lookup key builder for the access-control match stage, with an AXI4-Lite
// configuration slave. Assumes the classification pipeline runs on aclk and
// offers one frame per cycle with no back-pressure.
// Function
// - Each key is formed as a four-, eight- or sixteen-word key according to its kind.
// - Each key kind has a fixed defined width in bits.
// - Fields are packed back to back in their defined order starting at entry bit 0.
// - In an eight-word ethertype key the type code sits in bits 3:0 and the pass flag in bit 4.
// - Eight-word keys carry a 4-bit type code 0, 3, 4, 5, 8 or 9 by kind.
// - Sixteen-word keys carry a 2-bit type code, 1 for seven-field and 2 for user-defined A.
// - Every key carries a pass flag, 1 for the first lookup and 0 for the second.
// - Every key carries the 8-bit policy group, defaulting to a per-port configured value.
// - The mask mode selector is 0 by default and 1 for frames from a loopback device.
// - The selector is 2 for masqueraded frames when masquerade masking is enabled.
// - The selector is 3 for enabled host-injected, virtual-device or loopback frames.
// - When several selector values qualify, the highest one is used.
// - In modes 0 to 2 the 53-bit ingress bitmap is one-hot on the port of that mode, or all zero for a port above 52.
// - In mode 3 the bitmap holds source flags, effective source port, pipeline point and action.
// - The multicast flag copies bit 40 of the destination MAC address.
`timescale 1ns/1ps

module alkb_key_builder
    import alkb_pkg::*;
#(
    parameter int WORD_W = 36,
    parameter int NUM_PORTS = 53,
    parameter logic [2:0] MASQ_ACTION_CODE = 3'h1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic frm_valid,
    input wire logic [3:0] frm_kind,
    input wire logic frm_first_lookup,
    input wire logic frm_group_override,
    input wire logic [ALKB_GROUP_W-1:0] frm_group,
    input wire logic [ALKB_PORT_W-1:0] frm_phys_port,
    input wire logic [ALKB_PORT_W-1:0] frm_looped_port,
    input wire logic [ALKB_PORT_W-1:0] frm_src_port,
    input wire logic frm_inject,
    input wire logic frm_loopback_rx,
    input wire logic frm_host_port_zero,
    input wire logic frm_host_port_one,
    input wire logic frm_virtual_device_zero,
    input wire logic frm_virtual_device_one,
    input wire logic [ALKB_PT_W-1:0] frm_pipeline_point,
    input wire logic [ALKB_ACT_W-1:0] frm_pipeline_action,
    input wire logic [47:0] frm_dest_mac,
    input wire logic [16*WORD_W-1:0] frm_tail,
    output logic key_valid,
    output logic [3:0] key_kind,
    output logic [4:0] key_words,
    output logic [16*WORD_W-1:0] key_data
);

    localparam int KEY_W = 16 * WORD_W;

    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_held;
        logic w_held;
        logic [11:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [3:0] ctrl;
        logic [NUM_PORTS-1:0][ALKB_GROUP_W-1:0] port_group;
        logic [15:0] key_count;
        logic key_valid;
        logic [3:0] key_kind;
        logic [4:0] key_words;
        logic [KEY_W-1:0] key_data;
    } alkb_state_t;

    alkb_state_t s_q, s_d;

    // Selector and bitmap for the current frame.
    logic masq_frame;
    logic [1:0] mode_sel;
    logic [ALKB_MASK_W-1:0] port_bitmap;
    logic [ALKB_GROUP_W-1:0] group_val;
    logic [ALKB_PORT_W-1:0] mode_port;
    logic mc_flag;
    logic [KEY_W-1:0] head;
    logic [KEY_W-1:0] packed_key;
    int head_w;
    int key_w;
    logic [4:0] words;

    ////////////////////////////////////////////////////////////////////////////
    // Mode selector, bitmap and field packing.

    always_comb begin
        masq_frame = (frm_inject && (frm_src_port != frm_phys_port))
                     || (frm_pipeline_action == MASQ_ACTION_CODE);
        // Tested from the highest value down so the highest qualifying mode wins.
        if ((frm_inject && s_q.ctrl[1])
            || ((frm_virtual_device_zero || frm_virtual_device_one) && s_q.ctrl[2])
            || (frm_loopback_rx && s_q.ctrl[3])) begin
            mode_sel = 2'h3;
        end else if (masq_frame && s_q.ctrl[0]) begin
            mode_sel = 2'h2;
        end else if (frm_loopback_rx) begin
            mode_sel = 2'h1;
        end else begin
            mode_sel = 2'h0;
        end

        case (mode_sel)
            2'h1: mode_port = frm_looped_port;
            2'h2: mode_port = frm_src_port;
            default: mode_port = frm_phys_port;
        endcase

        port_bitmap = '0;
        if (mode_sel == 2'h3) begin
            port_bitmap[0] = frm_host_port_zero;
            port_bitmap[1] = frm_host_port_one;
            port_bitmap[2] = frm_virtual_device_zero;
            port_bitmap[3] = frm_virtual_device_one;
            port_bitmap[ALKB_M3_SRC_LSB +: ALKB_PORT_W] = frm_src_port;
            port_bitmap[ALKB_M3_PT_LSB +: ALKB_PT_W] = frm_pipeline_point;
            port_bitmap[ALKB_M3_ACT_LSB +: ALKB_ACT_W] = frm_pipeline_action;
        end else if (int'(mode_port) < ALKB_MASK_W) begin
            port_bitmap[mode_port] = 1'b1;
        end

        // A port beyond the table falls back to group zero rather than reading out of range.
        if (frm_group_override) begin
            group_val = frm_group;
        end else if (int'(frm_phys_port) < NUM_PORTS) begin
            group_val = s_q.port_group[frm_phys_port];
        end else begin
            group_val = '0;
        end
        mc_flag = frm_dest_mac[ALKB_MC_BIT];

        head = '0;
        case (frm_kind)
            ALKB_IPV4_VLAN: begin
                head[ALKB_QUAD_FIRST] = frm_first_lookup;
                head[ALKB_QUAD_FIRST+1 +: ALKB_GROUP_W] = group_val;
                head_w = ALKB_QUAD_FIRST + 1 + ALKB_GROUP_W;
            end
            ALKB_IP_SEVEN, ALKB_USER_A: begin
                head[1:0] = (frm_kind == ALKB_IP_SEVEN) ? ALKB_SIXTEEN_IP_SEVEN : ALKB_SIXTEEN_USER_A;
                head[ALKB_SIXTEEN_FIRST] = frm_first_lookup;
                head[ALKB_SIXTEEN_FIRST+1 +: ALKB_GROUP_W] = group_val;
                head[ALKB_SIXTEEN_FIRST+1+ALKB_GROUP_W +: 2] = mode_sel;
                head[ALKB_SIXTEEN_FIRST+3+ALKB_GROUP_W +: ALKB_MASK_W] = port_bitmap;
                head[ALKB_SIXTEEN_FIRST+3+ALKB_GROUP_W+ALKB_MASK_W] = mc_flag;
                head_w = ALKB_SIXTEEN_FIRST + 4 + ALKB_GROUP_W + ALKB_MASK_W;
            end
            default: begin
                case (frm_kind)
                    ALKB_ARP: head[3:0] = ALKB_OCTO_ARP;
                    ALKB_IPV4_TRANSPORT: head[3:0] = ALKB_OCTO_IPV4_TRANSPORT;
                    ALKB_IPV4_MISC: head[3:0] = ALKB_OCTO_IPV4_MISC;
                    ALKB_USER_B: head[3:0] = ALKB_OCTO_USER_B;
                    ALKB_IPV6_VLAN: head[3:0] = ALKB_OCTO_IPV6_VLAN;
                    default: head[3:0] = ALKB_OCTO_MAC_ETHERTYPE_KEY;
                endcase
                head[ALKB_OCTO_FIRST] = frm_first_lookup;
                head[ALKB_OCTO_FIRST+1 +: ALKB_GROUP_W] = group_val;
                // The IPv6 VLAN key carries no selector, bitmap or multicast flag.
                if (frm_kind == ALKB_IPV6_VLAN) begin
                    head_w = ALKB_OCTO_FIRST + 1 + ALKB_GROUP_W;
                end else begin
                    head[ALKB_OCTO_FIRST+1+ALKB_GROUP_W +: 2] = mode_sel;
                    head[ALKB_OCTO_FIRST+3+ALKB_GROUP_W +: ALKB_MASK_W] = port_bitmap;
                    head[ALKB_OCTO_FIRST+3+ALKB_GROUP_W+ALKB_MASK_W] = mc_flag;
                    head_w = ALKB_OCTO_FIRST + 4 + ALKB_GROUP_W + ALKB_MASK_W;
                end
            end
        endcase

        case (frm_kind)
            ALKB_IPV4_VLAN: key_w = ALKB_W_IPV4_VLAN;
            ALKB_MAC_ETHERTYPE_KEY: key_w = ALKB_W_MAC_ETHERTYPE_KEY;
            ALKB_ARP: key_w = ALKB_W_ARP;
            ALKB_IPV4_TRANSPORT: key_w = ALKB_W_IPV4_TRANSPORT;
            ALKB_IPV4_MISC: key_w = ALKB_W_IPV4_MISC;
            ALKB_USER_B: key_w = ALKB_W_USER_B;
            ALKB_IPV6_VLAN: key_w = ALKB_W_IPV6_VLAN;
            ALKB_IP_SEVEN: key_w = ALKB_W_IP_SEVEN;
            default: key_w = ALKB_W_USER_A;
        endcase
        case (frm_kind)
            ALKB_IPV4_VLAN: words = 5'(ALKB_QUAD_WORDS);
            ALKB_IP_SEVEN, ALKB_USER_A: words = 5'(ALKB_SIXTEEN_WORDS);
            default: words = 5'(ALKB_OCTO_WORDS);
        endcase

        // The pipeline's remaining fields follow the head; everything past the width is cleared.
        packed_key = head | (frm_tail << head_w);
        for (int i = 0; i < KEY_W; i++) begin
            if (i >= key_w) begin
                packed_key[i] = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register slave and key register.

    logic [11:0] wr_addr;
    logic [31:0] rd_word;
    logic rd_hit;
    logic wr_hit;
    int wr_idx;
    int rd_idx;

    always_comb begin
        s_d = s_q;
        wr_addr = s_q.aw_held ? s_q.awaddr : s_axi_awaddr;
        wr_idx = (int'(wr_addr) - int'(ALKB_GROUP_BASE)) >> 2;
        rd_idx = (int'(s_axi_araddr) - int'(ALKB_GROUP_BASE)) >> 2;

        if (s_axi_awvalid && s_q.awready) begin
            s_d.aw_held = 1'b1;
            s_d.awaddr = s_axi_awaddr;
            s_d.awready = 1'b0;
        end
        if (s_axi_wvalid && s_q.wready) begin
            s_d.w_held = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
            s_d.wready = 1'b0;
        end
        if (s_d.aw_held && s_d.w_held && !s_q.bvalid) begin
            wr_hit = 1'b1;
            if (s_d.awaddr[11:2] == ALKB_CTRL_ADDR[11:2]) begin
                if (s_d.wstrb[0]) begin
                    s_d.ctrl = s_d.wdata[3:0];
                end
            end else if (s_d.awaddr >= ALKB_GROUP_BASE && wr_idx < NUM_PORTS) begin
                if (s_d.wstrb[0]) begin
                    s_d.port_group[wr_idx] = s_d.wdata[ALKB_GROUP_W-1:0];
                end
            end else if (s_d.awaddr[11:2] != ALKB_STATUS_ADDR[11:2]) begin
                wr_hit = 1'b0;
            end
            s_d.bresp = wr_hit ? ALKB_RESP_OKAY : ALKB_RESP_SLVERR;
            s_d.bvalid = 1'b1;
            s_d.aw_held = 1'b0;
            s_d.w_held = 1'b0;
        end else begin
            wr_hit = 1'b0;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
            s_d.awready = 1'b1;
            s_d.wready = 1'b1;
        end

        rd_hit = 1'b1;
        rd_word = '0;
        if (s_axi_araddr[11:2] == ALKB_CTRL_ADDR[11:2]) begin
            rd_word[3:0] = s_q.ctrl;
        end else if (s_axi_araddr[11:2] == ALKB_STATUS_ADDR[11:2]) begin
            rd_word = {12'h000, s_q.key_kind, s_q.key_count};
        end else if (s_axi_araddr >= ALKB_GROUP_BASE && rd_idx < NUM_PORTS) begin
            rd_word[ALKB_GROUP_W-1:0] = s_q.port_group[rd_idx];
        end else begin
            rd_hit = 1'b0;
        end
        if (s_axi_arvalid && s_q.arready) begin
            s_d.arready = 1'b0;
            s_d.rvalid = 1'b1;
            s_d.rdata = rd_word;
            s_d.rresp = rd_hit ? ALKB_RESP_OKAY : ALKB_RESP_SLVERR;
        end
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
            s_d.arready = 1'b1;
        end

        s_d.key_valid = frm_valid;
        if (frm_valid) begin
            s_d.key_kind = frm_kind;
            s_d.key_words = words;
            s_d.key_data = packed_key;
            s_d.key_count = s_q.key_count + 16'h0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.awready <= 1'b1;
            s_q.wready <= 1'b1;
            s_q.arready <= 1'b1;
            s_q.ctrl <= ALKB_CTRL_RESET[3:0];
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready = s_q.awready;
    assign s_axi_wready = s_q.wready;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign s_axi_rvalid = s_q.rvalid;
    assign key_valid = s_q.key_valid;
    assign key_kind = s_q.key_kind;
    assign key_words = s_q.key_words;
    assign key_data = s_q.key_data;

endmodule

/* File: hw/alkb_pkg.sv */
// Constants and types shared by the access-control lookup key builder.
// Assumes a single core clock domain; no file here holds logic.
package alkb_pkg;

    // Key kinds offered by the classification pipeline.
    typedef enum logic [3:0] {
        ALKB_IPV4_VLAN = 4'h0,
        ALKB_MAC_ETHERTYPE_KEY = 4'h1,
        ALKB_ARP = 4'h2,
        ALKB_IPV4_TRANSPORT = 4'h3,
        ALKB_IPV4_MISC = 4'h4,
        ALKB_USER_B = 4'h5,
        ALKB_IPV6_VLAN = 4'h6,
        ALKB_IP_SEVEN = 4'h7,
        ALKB_USER_A = 4'h8
    } alkb_kind_t;

    // Words used by each size class.
    localparam int ALKB_QUAD_WORDS = 4;
    localparam int ALKB_OCTO_WORDS = 8;
    localparam int ALKB_SIXTEEN_WORDS = 16;

    // Defined key widths in bits.
    localparam int ALKB_W_IPV4_VLAN = 88;
    localparam int ALKB_W_MAC_ETHERTYPE_KEY = 271;
    localparam int ALKB_W_ARP = 210;
    localparam int ALKB_W_IPV4_TRANSPORT = 283;
    localparam int ALKB_W_IPV4_MISC = 274;
    localparam int ALKB_W_USER_B = 284;
    localparam int ALKB_W_IPV6_VLAN = 284;
    localparam int ALKB_W_IP_SEVEN = 567;
    localparam int ALKB_W_USER_A = 546;

    // Type code values.
    localparam logic [3:0] ALKB_OCTO_MAC_ETHERTYPE_KEY = 4'h0;
    localparam logic [3:0] ALKB_OCTO_ARP = 4'h3;
    localparam logic [3:0] ALKB_OCTO_IPV4_TRANSPORT = 4'h4;
    localparam logic [3:0] ALKB_OCTO_IPV4_MISC = 4'h5;
    localparam logic [3:0] ALKB_OCTO_USER_B = 4'h8;
    localparam logic [3:0] ALKB_OCTO_IPV6_VLAN = 4'h9;
    localparam logic [1:0] ALKB_SIXTEEN_IP_SEVEN = 2'h1;
    localparam logic [1:0] ALKB_SIXTEEN_USER_A = 2'h2;

    // Field widths.
    localparam int ALKB_GROUP_W = 8;
    localparam int ALKB_MASK_W = 53;
    localparam int ALKB_PORT_W = 6;
    localparam int ALKB_PT_W = 5;
    localparam int ALKB_ACT_W = 3;

    // Field positions inside the ingress bitmap when the mode selector is 3.
    localparam int ALKB_M3_SRC_LSB = 4;
    localparam int ALKB_M3_PT_LSB = 44;
    localparam int ALKB_M3_ACT_LSB = 49;

    // Field start positions per size class: pass flag, group, selector, bitmap, multicast, tail.
    localparam int ALKB_OCTO_FIRST = 4;
    localparam int ALKB_SIXTEEN_FIRST = 2;
    localparam int ALKB_QUAD_FIRST = 0;

    // Bit of the destination MAC address that marks multicast.
    localparam int ALKB_MC_BIT = 40;

    // Register map, byte addresses.
    localparam logic [11:0] ALKB_CTRL_ADDR = 12'h000;
    localparam logic [11:0] ALKB_STATUS_ADDR = 12'h004;
    localparam logic [11:0] ALKB_GROUP_BASE = 12'h100;
    localparam logic [31:0] ALKB_CTRL_RESET = 32'h0000_0000;
    localparam logic [1:0] ALKB_RESP_OKAY = 2'h0;
    localparam logic [1:0] ALKB_RESP_SLVERR = 2'h2;

endpackage

/* File: tb/alkb_key_monitor.sv */
// Concurrent checks on the key builder's frame and key ports.
// Assumes binding to alkb_key_builder, one clock, synchronous active-low reset.
`timescale 1ns/1ps
module alkb_key_monitor
    import alkb_pkg::*;
#(
    parameter int WORD_W = 36
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic frm_valid,
    input wire logic [3:0] frm_kind,
    input wire logic frm_first_lookup,
    input wire logic frm_group_override,
    input wire logic [ALKB_GROUP_W-1:0] frm_group,
    input wire logic [47:0] frm_dest_mac,
    input wire logic key_valid,
    input wire logic [3:0] key_kind,
    input wire logic [4:0] key_words,
    input wire logic [16*WORD_W-1:0] key_data
);
    function automatic logic [3:0] octo_code(input logic [3:0] k);
        case (k)
            4'h2: return 4'h3;
            4'h3: return 4'h4;
            4'h4: return 4'h5;
            4'h5: return 4'h8;
            4'h6: return 4'h9;
            default: return 4'h0;
        endcase
    endfunction
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_KEY_PULSE: assert property (key_valid == $past(frm_valid))
        else $error("key pulse does not follow a frame");
    AST_QUAD_WORDS: assert property (key_valid && key_kind == 4'h0 |-> key_words == 5'h04)
        else $error("four-word key has wrong size");
    AST_WIDE_WORDS: assert property (key_valid && key_kind >= 4'h7 |-> key_words == 5'h10)
        else $error("sixteen-word key has wrong size");
    AST_OCTO_TYPE: assert property (key_valid && key_words == 5'h08 |-> key_data[3:0] == octo_code(key_kind))
        else $error("eight-word type code wrong");
    AST_SIXTEEN_TYPE: assert property (key_valid && key_words == 5'h10 |->
        key_data[1:0] == ((key_kind == 4'h7) ? 2'h1 : 2'h2))
        else $error("sixteen-word type code wrong");
    AST_ETYPE_PASS: assert property (frm_valid && frm_kind == 4'h1 |=>
        key_data[4] == $past(frm_first_lookup) && key_data[3:0] == 4'h0)
        else $error("ethertype head misplaced");
    AST_SEVEN_PASS: assert property (frm_valid && frm_kind == 4'h7 |=> key_data[2] == $past(frm_first_lookup))
        else $error("pass flag wrong in sixteen-word key");
    AST_GROUP: assert property (frm_valid && frm_group_override && frm_kind == 4'h1 |=>
        key_data[12:5] == $past(frm_group))
        else $error("policy group not carried");
    AST_MC: assert property (frm_valid && frm_kind == 4'h1 |=> key_data[68] == $past(frm_dest_mac[40]))
        else $error("multicast flag wrong");
    AST_QUAD_TAIL: assert property (key_valid && key_kind == 4'h0 |-> (key_data >> 88) == '0)
        else $error("bits above key width not zero");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind alkb_key_builder alkb_key_monitor #(.WORD_W(WORD_W)) u_key_mon (.aclk(aclk), .aresetn(aresetn),
    .frm_valid(frm_valid), .frm_kind(frm_kind), .frm_first_lookup(frm_first_lookup),
    .frm_group_override(frm_group_override), .frm_group(frm_group), .frm_dest_mac(frm_dest_mac),
    .key_valid(key_valid), .key_kind(key_kind), .key_words(key_words), .key_data(key_data));

/* File: tb/alkb_match_model.sv */
// Model of the entry match memory that takes each built key.
// Assumes keys arrive as one-cycle pulses on aclk.
`timescale 1ns/1ps
module alkb_match_model #(
    parameter int WORD_W = 36
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic key_valid,
    input wire logic [4:0] key_words,
    input wire logic [16*WORD_W-1:0] key_data,
    input wire logic [16*WORD_W-1:0] entry,
    output logic hit_q,
    output logic [15:0] keys_q
);
    logic [16*WORD_W-1:0] care;
    // Entries share the key packing, so only the used words are compared; the rest is ignored.
    assign care = {(16*WORD_W){1'b1}} >> ((16 - int'(key_words)) * WORD_W);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hit_q <= 1'b0;
            keys_q <= 16'h0000;
        end else if (key_valid) begin
            hit_q <= ((key_data ^ entry) & care) == '0;
            keys_q <= keys_q + 16'h0001;
        end
    end
endmodule

/* File: tb/alkb_tb_top.sv */
// Self-checking bench for the lookup key builder.
// Assumes the design under hw/ and the match model and monitor beside this file.
`timescale 1ns/1ps
module tb_top;
    import alkb_pkg::*;
    localparam int KW = 16 * 36;
    localparam int OC[9] = '{0, 0, 3, 4, 5, 8, 9, 0, 0};
    localparam int WID[9] = '{88, 271, 210, 283, 274, 284, 284, 567, 546};
    localparam int WRD[9] = '{4, 8, 8, 8, 8, 8, 8, 16, 16};
    localparam logic [7:0] GRP5 = 8'h5a;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, key_valid, hit;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp;
    logic frm_valid = 1'b0, frm_first_lookup = 1'b0, frm_group_override = 1'b0, frm_inject = 1'b0;
    logic frm_loopback_rx = 1'b0, frm_hp1 = 1'b0, frm_vd0 = 1'b0, frm_hp0 = 1'b0, frm_vd1 = 1'b0;
    logic [3:0] frm_kind = 4'h0, key_kind;
    logic [4:0] frm_pipeline_point = 5'h15, key_words;
    logic [2:0] frm_pipeline_action = 3'h0;
    logic [7:0] frm_group = 8'hc3;
    logic [5:0] frm_phys_port = 6'h05, frm_looped_port = 6'h07, frm_src_port = 6'h09;
    logic [47:0] frm_dest_mac = 48'h0;
    logic [KW-1:0] frm_tail = '1, key_data, entry = '0, exp_key;
    logic [15:0] keys_seen;
    int err_count = 0, n_tests = 0;
    initial begin
        forever #50 aclk = ~aclk;
    end
    alkb_key_builder i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .frm_valid(frm_valid),
        .frm_kind(frm_kind), .frm_first_lookup(frm_first_lookup), .frm_group_override(frm_group_override),
        .frm_group(frm_group), .frm_phys_port(frm_phys_port), .frm_looped_port(frm_looped_port),
        .frm_src_port(frm_src_port), .frm_inject(frm_inject), .frm_loopback_rx(frm_loopback_rx),
        .frm_host_port_zero(frm_hp0), .frm_host_port_one(frm_hp1), .frm_virtual_device_zero(frm_vd0),
        .frm_virtual_device_one(frm_vd1), .frm_pipeline_point(frm_pipeline_point),
        .frm_pipeline_action(frm_pipeline_action), .frm_dest_mac(frm_dest_mac), .frm_tail(frm_tail),
        .key_valid(key_valid), .key_kind(key_kind), .key_words(key_words), .key_data(key_data));
    alkb_match_model i_mem (.aclk(aclk), .aresetn(aresetn), .key_valid(key_valid), .key_words(key_words),
        .key_data(key_data), .entry(entry), .hit_q(hit), .keys_q(keys_seen));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [KW-1:0] got, input logic [KW-1:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 40);
        r = bresp;
        bready <= 1'b0;
        if (n >= 40) chk(KW'(0), KW'(1));
    endtask
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 40);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (n >= 40) chk(KW'(0), KW'(1));
    endtask
    function automatic logic [KW-1:0] build(input logic [1:0] sel, input logic [52:0] bm);
        logic [KW-1:0] k;
        logic [KW-1:0] f;
        int kd;
        kd = int'(frm_kind);
        f = KW'(frm_first_lookup);
        k = KW'(frm_group_override ? frm_group : GRP5);
        if (kd == 0) k = f | (k << 1) | (frm_tail << 9);
        else if (kd == 6) k = KW'(OC[6]) | (f << 4) | (k << 5) | (frm_tail << 13);
        else if (kd < 7) k = KW'(OC[kd]) | (f << 4) | (k << 5) | (KW'(sel) << 13) | (KW'(bm) << 15)
            | (KW'(frm_dest_mac[40]) << 68) | (frm_tail << 69);
        else k = KW'(kd - 6) | (f << 2) | (k << 3) | (KW'(sel) << 11) | (KW'(bm) << 13)
            | (KW'(frm_dest_mac[40]) << 66) | (frm_tail << 67);
        return k & ((KW'(1) << WID[kd]) - KW'(1));
    endfunction
    // Attributes are set by the caller one edge earlier, so they have settled when the key is predicted.
    task automatic run_key(input logic [1:0] sel, input logic [52:0] bm);
        @(posedge aclk);
        exp_key = build(sel, bm);
        frm_valid <= 1'b1;
        entry <= exp_key;
        @(posedge aclk);
        frm_valid <= 1'b0;
        @(negedge aclk);
        chk(KW'(key_valid), KW'(1));
        chk(key_data, exp_key);
        chk(KW'({key_kind, key_words}), KW'({frm_kind, 5'(WRD[frm_kind])}));
        @(negedge aclk);
        chk(KW'({hit, key_valid}), KW'(2'h2));
    endtask
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        chk(KW'(key_valid), KW'(0));
        axi_rd(ALKB_CTRL_ADDR, d, r);
        chk(KW'({r, d}), KW'(34'h0));
        axi_rd(12'h800, d, r);
        chk(KW'({r, d}), KW'({2'h2, 32'h0}));
        axi_wr(12'h800, 32'h0000_00ff, r);
        chk(KW'(r), KW'(2'h2));
        axi_wr(12'h114, {24'h0, GRP5}, r);
        axi_rd(12'h114, d, r);
        chk(KW'({r, d}), KW'({2'h0, 24'h0, GRP5}));
    endtask
    task automatic t_kinds();
        for (int kd = 0; kd < 9; kd++) begin
            @(posedge aclk);
            frm_kind <= 4'(kd);
            frm_first_lookup <= kd[1];
            frm_group_override <= kd[0];
            frm_dest_mac <= {7'h0, kd[0], 40'h0};
            run_key(2'h0, 53'h1 << 5);
        end
    endtask
    task automatic mode_case(input logic [3:0] ctrl, input logic inj, input logic lbk, input logic vd0,
                             input logic [2:0] act, input logic [1:0] sel);
        logic [52:0] bm;
        logic [1:0] r;
        axi_wr(ALKB_CTRL_ADDR, {28'h0, ctrl}, r);
        bm = (sel == 2'h0) ? 53'h1 << 5 : (sel == 2'h1) ? 53'h1 << 7 : (sel == 2'h2) ? 53'h1 << 9
            : {1'b0, act, 5'h15, 34'h0, 6'h09, act[2], vd0, inj, lbk};
        @(posedge aclk);
        frm_kind <= 4'h1;
        frm_group_override <= 1'b0;
        frm_inject <= inj;
        frm_hp1 <= inj;
        frm_loopback_rx <= lbk;
        frm_vd0 <= vd0;
        // Host port zero follows loopback and virtual device one follows action bit 2.
        frm_hp0 <= lbk;
        frm_vd1 <= act[2];
        frm_pipeline_action <= act;
        run_key(sel, bm);
    endtask
    task automatic t_count();
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(ALKB_STATUS_ADDR, d, r);
        chk(KW'({r, d, keys_seen}), KW'({2'h0, 32'h0001_0012, 16'h0012}));
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        err_count++;
        $display("[ERR] %0t got %h exp %h", $time, 1'b0, 1'b1);
        end_sim();
    end
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_kinds();
        mode_case(4'h0, 1'b0, 1'b1, 1'b0, 3'h0, 2'h1);
        mode_case(4'h0, 1'b1, 1'b0, 1'b0, 3'h0, 2'h0);
        mode_case(4'h1, 1'b1, 1'b0, 1'b0, 3'h0, 2'h2);
        mode_case(4'h1, 1'b0, 1'b1, 1'b0, 3'h1, 2'h2);
        mode_case(4'h2, 1'b1, 1'b0, 1'b0, 3'h0, 2'h3);
        mode_case(4'h4, 1'b0, 1'b0, 1'b1, 3'h5, 2'h3);
        mode_case(4'h4, 1'b0, 1'b0, 1'b0, 3'h4, 2'h3);
        mode_case(4'h8, 1'b0, 1'b1, 1'b0, 3'h0, 2'h3);
        mode_case(4'hf, 1'b1, 1'b1, 1'b0, 3'h1, 2'h3);
        t_count();
        end_sim();
    end
endmodule
